//--- hw/apm_defs.vh
// Register map, field positions and reset values for the address/GPIO pin mux.
// Assumes the includer works on 32-bit AXI4-Lite data with word-aligned byte addresses.
`ifndef APM_DEFS_VH
`define APM_DEFS_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define APM_OFS_BUS_CTRL   12'h000
`define APM_OFS_E_SEL      12'h004
`define APM_OFS_E_DIR      12'h008
`define APM_OFS_E_DOUT     12'h00C
`define APM_OFS_E_PULLUP   12'h010
`define APM_OFS_E_PINS     12'h014
`define APM_OFS_A_SEL      12'h020
`define APM_OFS_A_DIR      12'h024
`define APM_OFS_A_DOUT     12'h028
`define APM_OFS_A_PULLUP   12'h02C
`define APM_OFS_A_PINS     12'h030

// ----------------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------------
`define APM_BIT_IDLE_DRIVE 0
`define APM_E_LO           2
`define APM_E_HI           3
`define APM_A_LO           0
`define APM_A_HI           7
`define APM_NPINS          10
`define APM_NCTRL          3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define APM_RST_IDLE_DRIVE 1'b0
`define APM_RST_E_SEL      2'b11
`define APM_RST_A_SEL      8'hFF
`define APM_RST_E_PULLUP   2'b11
`define APM_RST_A_PULLUP   8'hFF
`define APM_RST_DIR_E      2'b00
`define APM_RST_DIR_A      8'h00
`define APM_RST_DOUT_E     2'b00
`define APM_RST_DOUT_A     8'h00

// ----------------------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------------------
`define APM_RESP_OKAY      2'b00
`define APM_RESP_SLVERR    2'b10

`endif

//--- hw/apm_pin_cell.v
// One shared pad: chooses between the address bus and a GPIO bit, drives the
// pad output, enable and pull-up from flip-flops, and synchronises the pad input.
// Assumes all control inputs come from logic on core_clk.
`timescale 1ns/1ps
module apm_pin_cell (
  input  wire core_clk,
  input  wire rst_n,
  input  wire addr_sel,
  input  wire addr_val,
  input  wire bus_drive,
  input  wire gpio_dir,
  input  wire gpio_out,
  input  wire pull_en,
  input  wire pad_i,
  output reg  pad_o_ff,
  output reg  pad_oe_ff,
  output reg  pad_pu_ff,
  output reg  pin_sync_ff
);

  reg  sync1_ff;
  wire nxt_pad_o;
  wire nxt_pad_oe;

  // --------------------------------------------------------------------------
  // Function select
  // --------------------------------------------------------------------------
  assign nxt_pad_o  = addr_sel ? addr_val : gpio_out;  // R1 R2
  assign nxt_pad_oe = addr_sel ? bus_drive : gpio_dir; // R3 R4 R6 R7

  // In reset the driver is off and the pull-up on.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_o_ff    <= 1'b0;
      pad_oe_ff   <= 1'b0; // R12
      pad_pu_ff   <= 1'b1; // R12
      sync1_ff    <= 1'b0;
      pin_sync_ff <= 1'b0;
    end else begin
      pad_o_ff    <= nxt_pad_o;
      pad_oe_ff   <= nxt_pad_oe;
      pad_pu_ff   <= pull_en; // R9
      sync1_ff    <= pad_i;
      pin_sync_ff <= sync1_ff;
    end
  end

endmodule // apm_pin_cell

//--- hw/apm_pin_mux.v
// Pin mux for address bits 6..15 shared with port E pins 2..3 and port A pins 0..7,
// with an AXI4-Lite register slave for selection, direction, data and pull-ups.
// Assumes emi_* inputs come from the memory interface on core_clk; pads are outside.
`timescale 1ns/1ps
`include "apm_defs.vh"

// What this block does
// (R1) In address function, port E pins 2-3 drive address bits 6 and 7.
// (R2) In address function, port A pins 0-7 drive address bits 8 to 15.
// (R3) Address 6-7 and control outputs float on idle bus unless idle drive set.
// (R4) Address 8-15 and control outputs float on idle bus unless idle drive set.
// (R5) Software should set idle drive to 1 to keep outputs driven when idle.
// (R6) Port E pins 2-3 are each independently GPIO input or output.
// (R7) Port A pins 0-7 are each independently GPIO input or output.
// (R8) After reset every shared pin selects the address-bus function.
// (R9) Clearing a port E pull-up enable bit turns that pin's pull-up off.
// (R10) Pull-up bits map by pin number: port E pin 2 is bit 2.
// (R11) Port A pin 0 is pull-up bit 0; clearing it disables the pull-up.
// (R12) During reset all drivers are off and all pull-ups are on.
module apm_pin_mux (
  input  wire        core_clk,
  input  wire        rst_n,
  // AXI4-Lite slave
  input  wire [11:0] s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Memory interface side
  input  wire [15:6] emi_addr,
  input  wire        emi_bus_active,
  input  wire [2:0]  emi_ctrl,
  output reg  [2:0]  emi_ctrl_pad_o_ff,
  output reg  [2:0]  emi_ctrl_pad_oe_ff,
  // Shared pads, index 0 is address bit 6 and index 9 is address bit 15
  input  wire [9:0]  addr_pad_i,
  output wire [9:0]  addr_pad_o,
  output wire [9:0]  addr_pad_oe,
  output wire [9:0]  addr_pad_pu
);

  // --------------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------------
  reg         idle_drive_select_ff;
  reg  [3:2]  port_e_sel_ff;
  reg  [3:2]  port_e_dir_ff;
  reg  [3:2]  port_e_dout_ff;
  reg  [3:2]  port_e_pullup_enable_ff;
  reg  [7:0]  port_a_sel_ff;
  reg  [7:0]  port_a_dir_ff;
  reg  [7:0]  port_a_dout_ff;
  reg  [7:0]  port_a_pullup_enable_ff;

  // --------------------------------------------------------------------------
  // Bus slave state
  // --------------------------------------------------------------------------
  reg         aw_got_ff;
  reg         w_got_ff;
  reg  [11:0] awaddr_ff;
  reg  [31:0] wdata_ff;
  reg  [3:0]  wstrb_ff;
  wire        aw_take;
  wire        w_take;
  wire        have_aw;
  wire        have_w;
  wire        wr_fire;
  wire [11:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0]  wr_strb;
  wire        wr_lane0;
  reg         wr_hit;
  wire        ar_take;
  reg  [31:0] nxt_rdata;
  reg         rd_hit;

  // --------------------------------------------------------------------------
  // Pin vectors
  // --------------------------------------------------------------------------
  wire [9:0]  pin_sel;
  wire [9:0]  pin_dir;
  wire [9:0]  pin_dout;
  wire [9:0]  pin_pull;
  wire [9:0]  pin_sync;
  wire        bus_drive;

  // --------------------------------------------------------------------------
  // Write channel
  // --------------------------------------------------------------------------
  // Address and data are held separately so either may arrive first.
  assign s_axi_awready = !aw_got_ff && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_ff && !s_axi_bvalid;
  assign aw_take       = s_axi_awvalid && s_axi_awready;
  assign w_take        = s_axi_wvalid && s_axi_wready;
  assign have_aw       = aw_got_ff || aw_take;
  assign have_w        = w_got_ff || w_take;
  assign wr_fire       = have_aw && have_w && !s_axi_bvalid;
  assign wr_addr       = aw_got_ff ? awaddr_ff : s_axi_awaddr;
  assign wr_data       = w_got_ff ? wdata_ff : s_axi_wdata;
  assign wr_strb       = w_got_ff ? wstrb_ff : s_axi_wstrb;
  // Every field sits in the low byte, so only that lane matters.
  assign wr_lane0      = wr_fire && wr_strb[0];

  always @* begin
    wr_hit = 1'b1;
    if (wr_addr == `APM_OFS_BUS_CTRL) begin
      wr_hit = 1'b1;
    end else if (wr_addr == `APM_OFS_E_SEL) begin
      wr_hit = 1'b1;
    end else if (wr_addr == `APM_OFS_E_DIR) begin
      wr_hit = 1'b1;
    end else if (wr_addr == `APM_OFS_E_DOUT) begin
      wr_hit = 1'b1;
    end else if (wr_addr == `APM_OFS_E_PULLUP) begin
      wr_hit = 1'b1;
    end else if (wr_addr == `APM_OFS_E_PINS) begin
      wr_hit = 1'b1;
    end else if (wr_addr == `APM_OFS_A_SEL) begin
      wr_hit = 1'b1;
    end else if (wr_addr == `APM_OFS_A_DIR) begin
      wr_hit = 1'b1;
    end else if (wr_addr == `APM_OFS_A_DOUT) begin
      wr_hit = 1'b1;
    end else if (wr_addr == `APM_OFS_A_PULLUP) begin
      wr_hit = 1'b1;
    end else if (wr_addr == `APM_OFS_A_PINS) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_got_ff    <= 1'b0;
      w_got_ff     <= 1'b0;
      awaddr_ff    <= 12'h000;
      wdata_ff     <= 32'h0000_0000;
      wstrb_ff     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `APM_RESP_OKAY;
    end else begin
      if (wr_fire) begin
        aw_got_ff    <= 1'b0;
        w_got_ff     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `APM_RESP_OKAY : `APM_RESP_SLVERR;
      end else begin
        if (aw_take) begin
          aw_got_ff <= 1'b1;
          awaddr_ff <= s_axi_awaddr;
        end
        if (w_take) begin
          w_got_ff <= 1'b1;
          wdata_ff <= s_axi_wdata;
          wstrb_ff <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------------
  // The pin-state registers are read-only; writes to them are accepted and dropped.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_drive_select_ff    <= `APM_RST_IDLE_DRIVE;
      port_e_sel_ff           <= `APM_RST_E_SEL;    // R8
      port_a_sel_ff           <= `APM_RST_A_SEL;    // R8
      port_e_dir_ff           <= `APM_RST_DIR_E;
      port_a_dir_ff           <= `APM_RST_DIR_A;
      port_e_dout_ff          <= `APM_RST_DOUT_E;
      port_a_dout_ff          <= `APM_RST_DOUT_A;
      port_e_pullup_enable_ff <= `APM_RST_E_PULLUP;
      port_a_pullup_enable_ff <= `APM_RST_A_PULLUP;
    end else if (wr_lane0) begin
      if (wr_addr == `APM_OFS_BUS_CTRL) begin
        idle_drive_select_ff <= wr_data[`APM_BIT_IDLE_DRIVE]; // R3 R4
      end else if (wr_addr == `APM_OFS_E_SEL) begin
        port_e_sel_ff <= wr_data[`APM_E_HI:`APM_E_LO];
      end else if (wr_addr == `APM_OFS_E_DIR) begin
        port_e_dir_ff <= wr_data[`APM_E_HI:`APM_E_LO]; // R6
      end else if (wr_addr == `APM_OFS_E_DOUT) begin
        port_e_dout_ff <= wr_data[`APM_E_HI:`APM_E_LO];
      end else if (wr_addr == `APM_OFS_E_PULLUP) begin
        port_e_pullup_enable_ff <= wr_data[`APM_E_HI:`APM_E_LO]; // R9 R10
      end else if (wr_addr == `APM_OFS_A_SEL) begin
        port_a_sel_ff <= wr_data[`APM_A_HI:`APM_A_LO];
      end else if (wr_addr == `APM_OFS_A_DIR) begin
        port_a_dir_ff <= wr_data[`APM_A_HI:`APM_A_LO]; // R7
      end else if (wr_addr == `APM_OFS_A_DOUT) begin
        port_a_dout_ff <= wr_data[`APM_A_HI:`APM_A_LO];
      end else if (wr_addr == `APM_OFS_A_PULLUP) begin
        port_a_pullup_enable_ff <= wr_data[`APM_A_HI:`APM_A_LO]; // R11
      end
    end
  end

  // --------------------------------------------------------------------------
  // Read channel
  // --------------------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  assign ar_take       = s_axi_arvalid && s_axi_arready;

  always @* begin
    nxt_rdata = 32'h0000_0000;
    rd_hit    = 1'b1;
    if (s_axi_araddr == `APM_OFS_BUS_CTRL) begin
      nxt_rdata[`APM_BIT_IDLE_DRIVE] = idle_drive_select_ff;
    end else if (s_axi_araddr == `APM_OFS_E_SEL) begin
      nxt_rdata[`APM_E_HI:`APM_E_LO] = port_e_sel_ff;
    end else if (s_axi_araddr == `APM_OFS_E_DIR) begin
      nxt_rdata[`APM_E_HI:`APM_E_LO] = port_e_dir_ff;
    end else if (s_axi_araddr == `APM_OFS_E_DOUT) begin
      nxt_rdata[`APM_E_HI:`APM_E_LO] = port_e_dout_ff;
    end else if (s_axi_araddr == `APM_OFS_E_PULLUP) begin
      nxt_rdata[`APM_E_HI:`APM_E_LO] = port_e_pullup_enable_ff;
    end else if (s_axi_araddr == `APM_OFS_E_PINS) begin
      nxt_rdata[`APM_E_HI:`APM_E_LO] = pin_sync[1:0]; // R6
    end else if (s_axi_araddr == `APM_OFS_A_SEL) begin
      nxt_rdata[`APM_A_HI:`APM_A_LO] = port_a_sel_ff;
    end else if (s_axi_araddr == `APM_OFS_A_DIR) begin
      nxt_rdata[`APM_A_HI:`APM_A_LO] = port_a_dir_ff;
    end else if (s_axi_araddr == `APM_OFS_A_DOUT) begin
      nxt_rdata[`APM_A_HI:`APM_A_LO] = port_a_dout_ff;
    end else if (s_axi_araddr == `APM_OFS_A_PULLUP) begin
      nxt_rdata[`APM_A_HI:`APM_A_LO] = port_a_pullup_enable_ff;
    end else if (s_axi_araddr == `APM_OFS_A_PINS) begin
      nxt_rdata[`APM_A_HI:`APM_A_LO] = pin_sync[9:2]; // R7
    end else begin
      rd_hit = 1'b0;
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `APM_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= nxt_rdata;
      s_axi_rresp  <= rd_hit ? `APM_RESP_OKAY : `APM_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Memory interface control outputs
  // --------------------------------------------------------------------------
  // With idle drive clear the pads float between accesses; setting it avoids
  // floating nets on the memory side, which is why software should set it.
  assign bus_drive = emi_bus_active || idle_drive_select_ff; // R3 R4 R5

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      emi_ctrl_pad_o_ff  <= 3'b000;
      emi_ctrl_pad_oe_ff <= 3'b000; // R12
    end else begin
      emi_ctrl_pad_o_ff  <= emi_ctrl;
      emi_ctrl_pad_oe_ff <= {`APM_NCTRL{bus_drive}}; // R3 R4
    end
  end

  // --------------------------------------------------------------------------
  // Shared pads
  // --------------------------------------------------------------------------
  // Index 0..1 are port E pins 2..3, index 2..9 are port A pins 0..7.
  assign pin_sel  = {port_a_sel_ff, port_e_sel_ff};
  assign pin_dir  = {port_a_dir_ff, port_e_dir_ff};
  assign pin_dout = {port_a_dout_ff, port_e_dout_ff};
  assign pin_pull = {port_a_pullup_enable_ff, port_e_pullup_enable_ff}; // R10 R11

  genvar gi;
  generate
    for (gi = 0; gi < `APM_NPINS; gi = gi + 1) begin : g_pin
      apm_pin_cell u_cell (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .addr_sel    (pin_sel[gi]),
        .addr_val    (emi_addr[gi + 6]), // R1 R2
        .bus_drive   (bus_drive),
        .gpio_dir    (pin_dir[gi]),
        .gpio_out    (pin_dout[gi]),
        .pull_en     (pin_pull[gi]),
        .pad_i       (addr_pad_i[gi]),
        .pad_o_ff    (addr_pad_o[gi]),
        .pad_oe_ff   (addr_pad_oe[gi]),
        .pad_pu_ff   (addr_pad_pu[gi]),
        .pin_sync_ff (pin_sync[gi])
      );
    end
  endgenerate

endmodule // apm_pin_mux

//--- testbench/apm_pad_model.sv
// Far side of the shared pads: external memory and other pad drivers.
// Assumes the bench drives ext_en/ext_val only where the mux does not drive.
`timescale 1ns/1ps
module apm_pad_model (
  input wire        core_clk,
  input wire [9:0]  pad_o,
  input wire [9:0]  pad_oe,
  input wire [9:0]  pad_pu,
  input wire [9:0]  ext_en,
  input wire [9:0]  ext_val,
  output wire [9:0] pad_lvl,
  output reg [15:0] clash
);
  // A floating pad without pull-up toggles, so a stale level never passes.
  reg [9:0] last_ff = 10'h000;
  assign pad_lvl = (pad_oe & pad_o) | (~pad_oe & ext_en & ext_val) |
                   (~pad_oe & ~ext_en & (pad_pu | ~last_ff));
  initial clash = 16'h0000;
  always @(posedge core_clk) begin
    last_ff <= pad_lvl;
    if (|(pad_oe & ext_en)) clash <= clash + 16'h0001;
  end
endmodule // apm_pad_model

//--- testbench/apm_pin_mux_checker.sv
// Concurrent checks on the ports of the address/GPIO pin mux.
// Assumes one clock, core_clk, and an asynchronous active-low rst_n.
`timescale 1ns/1ps
module apm_pin_mux_checker (
  input wire        core_clk,
  input wire        rst_n,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [15:6] emi_addr,
  input wire        emi_bus_active,
  input wire [2:0]  emi_ctrl,
  input wire [2:0]  emi_ctrl_pad_o_ff,
  input wire [2:0]  emi_ctrl_pad_oe_ff,
  input wire [9:0]  addr_pad_o,
  input wire [9:0]  addr_pad_oe,
  input wire [9:0]  addr_pad_pu
);
  // Until the first write address is taken, the reset configuration must hold.
  reg  live_ff;
  reg  dflt_ff;
  wire dflt;
  assign dflt = live_ff && dflt_ff;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      live_ff <= 1'b0;
      dflt_ff <= 1'b1;
    end else begin
      live_ff <= 1'b1;
      if (s_axi_awvalid && s_axi_awready) dflt_ff <= 1'b0;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_addr_lo;
    dflt |-> addr_pad_o[1:0] == $past(emi_addr[7:6]);
  endproperty
  a_addr_lo: assert property (p_addr_lo) else $error("low address pads wrong");
  property p_addr_hi;
    dflt |-> addr_pad_o[9:2] == $past(emi_addr[15:8]);
  endproperty
  a_addr_hi: assert property (p_addr_hi) else $error("high address pads wrong");
  property p_oe_lo;
    dflt |-> addr_pad_oe[1:0] == {2{$past(emi_bus_active)}};
  endproperty
  a_oe_lo: assert property (p_oe_lo) else $error("low pad enable wrong");
  property p_oe_hi;
    dflt |-> addr_pad_oe[9:2] == {8{$past(emi_bus_active)}};
  endproperty
  a_oe_hi: assert property (p_oe_hi) else $error("high pad enable wrong");
  property p_pu_dflt;
    dflt |-> addr_pad_pu == 10'h3ff;
  endproperty
  a_pu_dflt: assert property (p_pu_dflt) else $error("pull-ups off after reset");
  property p_rst;
    disable iff (1'b0) !rst_n |-> addr_pad_oe == 10'h000 && addr_pad_pu == 10'h3ff;
  endproperty
  a_rst: assert property (p_rst) else $error("pads wrong in reset");
  property p_ctl_oe;
    emi_bus_active |=> emi_ctrl_pad_oe_ff == 3'h7;
  endproperty
  a_ctl_oe: assert property (p_ctl_oe) else $error("control pads float in access");
  property p_ctl_o;
    1'b1 |=> emi_ctrl_pad_o_ff == $past(emi_ctrl);
  endproperty
  a_ctl_o: assert property (p_ctl_o) else $error("control pads lag wrong");
endmodule // apm_pin_mux_checker

bind apm_pin_mux apm_pin_mux_checker u_chk (.core_clk(core_clk), .rst_n(rst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .emi_addr(emi_addr),
  .emi_bus_active(emi_bus_active), .emi_ctrl(emi_ctrl), .emi_ctrl_pad_o_ff(emi_ctrl_pad_o_ff),
  .emi_ctrl_pad_oe_ff(emi_ctrl_pad_oe_ff), .addr_pad_o(addr_pad_o), .addr_pad_oe(addr_pad_oe),
  .addr_pad_pu(addr_pad_pu));

//--- testbench/tb.sv
// Self-checking bench for the address/GPIO pin mux.
// Assumes the checker binds itself and the pad model sits on the pads.
`timescale 1ns/1ps
module tb;
  reg         core_clk, rst_n, awvalid, wvalid, bready, arvalid, rready, act;
  reg  [11:0] awaddr, araddr;
  reg  [31:0] wdata;
  reg  [15:6] eaddr;
  reg  [2:0]  ectl;
  reg  [9:0]  ext_en, ext_val, pa;
  reg         pact;
  wire        awready, wready, bvalid, arready, rvalid;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [2:0]  ctl_o, ctl_oe;
  wire [9:0]  pad_o, pad_oe, pad_pu, pad_i;
  wire [15:0] clash;
  integer     err_count, n_checks, i;
  apm_pin_mux uut (.core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .emi_addr(eaddr), .emi_bus_active(act), .emi_ctrl(ectl),
    .emi_ctrl_pad_o_ff(ctl_o), .emi_ctrl_pad_oe_ff(ctl_oe), .addr_pad_i(pad_i),
    .addr_pad_o(pad_o), .addr_pad_oe(pad_oe), .addr_pad_pu(pad_pu));
  apm_pad_model u_mem (.core_clk(core_clk), .pad_o(pad_o), .pad_oe(pad_oe), .pad_pu(pad_pu),
    .ext_en(ext_en), .ext_val(ext_val), .pad_lvl(pad_i), .clash(clash));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task complete_run;
    begin
      $display("Checks %0d, errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  task to_chk(input done);
    begin
      if (!done) begin
        chk(32'h0, 32'h1);
        complete_run;
      end
    end
  endtask
  task wr(input [11:0] a, input [31:0] d, input [1:0] er);
    integer n;
    reg     ad, dd, bd;
    begin
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      ad = 0;
      dd = 0;
      bd = 0;
      for (n = 0; n < 40 && !bd; n = n + 1) begin
        @(posedge core_clk);
        if (ad && dd && bvalid) begin
          bd = 1;
          bready <= 1'b0;
          chk(bresp, er);
        end
        if (!ad && awready) begin
          ad = 1;
          awvalid <= 1'b0;
        end
        if (!dd && wready) begin
          dd = 1;
          wvalid <= 1'b0;
        end
      end
      to_chk(bd);
    end
  endtask
  task rd(input [11:0] a, input [31:0] ed, input [1:0] er);
    integer n;
    reg     ac, ok;
    begin
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      ac = 0;
      ok = 0;
      for (n = 0; n < 40 && !ok; n = n + 1) begin
        @(posedge core_clk);
        if (ac && rvalid) begin
          ok = 1;
          rready <= 1'b0;
          chk(rdata, ed);
          chk(rresp, er);
        end
        if (!ac && arready) begin
          ac = 1;
          arvalid <= 1'b0;
        end
      end
      to_chk(ok);
    end
  endtask
  task settle;
    begin
      repeat (3) @(posedge core_clk);
      #1;
    end
  endtask
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task t_addr;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        @(posedge core_clk);
        pa = eaddr;
        pact = act;
        eaddr <= 10'h2a5 ^ (i * 10'h049);
        act <= i[0] | i[1];
        ectl <= i[2:0];
        #1;
        chk(pad_o, pa);
        chk(pad_oe, {10{pact}});
        chk(ctl_oe, {3{pact}});
        chk(pad_i, pact ? pa : 10'h3ff);
      end
      rd(12'h000, 32'h0, 2'h0);
      rd(12'h004, 32'hc, 2'h0);
      rd(12'h020, 32'hff, 2'h0);
      rd(12'h010, 32'hc, 2'h0);
      rd(12'h02c, 32'hff, 2'h0);
    end
  endtask
  task t_idle;
    begin
      wr(12'h000, 32'h1, 2'h0);
      act <= 1'b0;
      settle;
      chk(pad_oe, 10'h3ff);
      chk(ctl_oe, 3'h7);
      wr(12'h000, 32'h0, 2'h0);
      settle;
      chk(pad_oe, 10'h000);
      chk(ctl_oe, 3'h0);
    end
  endtask
  task t_gpio;
    begin
      @(posedge core_clk);
      ext_val <= 10'h002;
      wr(12'h004, 32'h0, 2'h0);
      wr(12'h020, 32'h0, 2'h0);
      // The far side may drive only once no pad is left on the address function.
      ext_en <= 10'h2a8;
      act <= 1'b1;
      wr(12'h008, 32'h4, 2'h0);
      wr(12'h024, 32'h55, 2'h0);
      wr(12'h00c, 32'hc, 2'h0);
      wr(12'h028, 32'hff, 2'h0);
      settle;
      chk(pad_oe, 10'h155);
      chk(pad_o & pad_oe, 10'h155);
      rd(12'h014, 32'hc, 2'h0);
      rd(12'h030, 32'h55, 2'h0);
      ext_en <= 10'h2a8;
      wr(12'h008, 32'h8, 2'h0);
      ext_en <= 10'h2a9;
      settle;
      chk(pad_oe, 10'h156);
      rd(12'h014, 32'h8, 2'h0);
    end
  endtask
  task t_pull;
    begin
      wr(12'h010, 32'h8, 2'h0);
      wr(12'h02c, 32'hfe, 2'h0);
      settle;
      chk(pad_pu, 10'h3fa);
      rd(12'h010, 32'h8, 2'h0);
    end
  endtask
  task t_err;
    begin
      wr(12'h040, 32'h1, 2'h2);
      rd(12'h040, 32'h0, 2'h2);
      wr(12'h014, 32'h0, 2'h0);
    end
  endtask
  task t_reset;
    begin
      @(posedge core_clk);
      rst_n <= 1'b0;
      ext_en <= 10'h000;
      #1;
      chk(pad_oe, 10'h000);
      chk(pad_pu, 10'h3ff);
      chk(ctl_oe, 3'h0);
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      rd(12'h004, 32'hc, 2'h0);
      rd(12'h020, 32'hff, 2'h0);
      rd(12'h02c, 32'hff, 2'h0);
      settle;
      chk(pad_oe, 10'h3ff);
      chk(pad_o, eaddr);
      chk(pad_pu, 10'h3ff);
    end
  endtask
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, act, pact} = 8'h80;
    {awaddr, araddr, wdata, eaddr, ectl, ext_en, ext_val, pa} = 0;
    err_count = 0;
    n_checks = 0;
    // Reset falls after time zero so every asynchronous reset branch sees a real edge.
    #1;
    rst_n = 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    chk(pad_oe, 10'h000);
    chk(pad_pu, 10'h3ff);
    chk(ctl_oe, 3'h0);
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    t_addr;
    t_idle;
    t_gpio;
    t_pull;
    t_err;
    t_reset;
    chk(clash, 0);
    complete_run;
  end
endmodule // tb
